// *** orc_regs.v ***
// Purpose: remote command registers and maintenance frame counters
// Assumes: management port strobes are one-cycle pulses, synchronous to ref_clk
// Notes: read data appears one cycle after the read strobe
`default_nettype none
`include "orc_defines.vh"

// Contract
// RULE_01: only a center-side unit uses the remote-command registers for frames.
// RULE_02: software keeps mode bits 7:6 at zero; they reset to zero.
// RULE_03: mode bits 5:4 are read-only, reset to 10, meaning extended support.
// RULE_04: in extended mode, mode bits 3:2 select the operation code.
// RULE_05: operating mode 00 uses own model info bytes in the frame.
// RULE_06: operating mode 10 fills model info from the three command registers.
// RULE_07: an issued remote command puts the address register into frame bits 39:32.
// RULE_08: an issued remote command puts the data register into frame bits 47:40.
// RULE_09: software loads the address register with the remote target address.
// RULE_10: software loads the data register with the remote data byte.
// RULE_11: sent counter counts each valid transmitted maintenance frame, 0 to 255.
// RULE_12: received counter counts frames with good CRC, opcode and direction.
// RULE_13: writing zero to the loop-back control register clears both counters.
// RULE_14: software avoids 0x22, 0x26, 0x2A, 0x2E in the first own model byte.
// RULE_15: counters wrap after 255; clear wins over increment.
module orc_regs (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // management register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_q,
    output reg         reg_rvalid_q,
    // converter role
    input  wire        center_side,
    // remote command issue from transmit control
    input  wire        remote_cmd_issue,
    // own model info bytes
    input  wire [7:0]  own_model_0,
    input  wire [7:0]  own_model_1,
    input  wire [7:0]  own_model_2,
    // maintenance frame events
    input  wire        tx_frame_valid,
    input  wire        rx_frame_done,
    input  wire        rx_crc_good,
    input  wire        rx_opcode_valid,
    input  wire        rx_dir_valid,
    // frame builder side
    output wire [23:0] model_info_field,
    output reg         ext_mode_q,
    output reg  [1:0]  operation_code_q,
    output reg         mode_reserved_q,
    output reg         remote_cmd_pending_q,
    // counters
    output wire [7:0]  sent_count,
    output wire [7:0]  received_count
);

    // address match helper, used for every register
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // extended mode check on an operating mode code
    function is_ext;
        input [1:0] m;
        begin
            is_ext = (m == `ORC_OPM_EXTENDED);
        end
    endfunction

    // reserved operating mode codes
    function is_rsv_mode;
        input [1:0] m;
        begin
            is_rsv_mode = (m != `ORC_OPM_NORMAL) && (m != `ORC_OPM_EXTENDED);
        end
    endfunction

    // writable part of the mode register, capability bits are not stored
    reg  [1:0] rsv_bits_q;
    reg  [1:0] rsv_bits_d;
    reg  [1:0] opc_bits_q;
    reg  [1:0] opc_bits_d;
    reg  [1:0] opm_bits_q;
    reg  [1:0] opm_bits_d;
    reg  [7:0] cmd_addr_q;
    reg  [7:0] cmd_addr_d;
    reg  [7:0] cmd_data_q;
    reg  [7:0] cmd_data_d;
    reg        pending_d;
    reg  [7:0] rdata_d;
    reg        rvalid_d;
    reg        ext_d;
    reg  [1:0] opc_d;
    reg        rsv_d;

    wire [7:0] mode_word;
    wire       wr_mode;
    wire       wr_addr;
    wire       wr_data;
    wire       cnt_clear;
    wire       rx_good;
    wire       center_ext;
    wire       center_cmd;
    wire       rd_hit;
    wire [7:0] mode_rst;

    // capability bits are constant, so they never take a write
    assign mode_word = {rsv_bits_q, `ORC_CAP_EXTENDED, opc_bits_q, opm_bits_q}; // [RULE_03]
    assign mode_rst  = `ORC_MODE_RST;

    assign wr_mode = reg_wr && hit(reg_addr, `ORC_OFF_MODE);
    assign wr_addr = reg_wr && hit(reg_addr, `ORC_OFF_ADDR);
    assign wr_data = reg_wr && hit(reg_addr, `ORC_OFF_DATA);

    // snoops writes to the loop-back control register, which lives elsewhere
    assign cnt_clear = reg_wr && hit(reg_addr, `ORC_OFF_LOOPBACK)
                       && (reg_wdata == `ORC_CNT_CLEAR_VAL); // [RULE_13]

    assign rx_good = rx_frame_done && rx_crc_good && rx_opcode_valid && rx_dir_valid; // [RULE_12]

    // terminal side never substitutes command bytes into its frames
    assign center_ext = center_side && is_ext(opm_bits_q);      // [RULE_01]
    assign center_cmd = center_side && remote_cmd_pending_q;    // [RULE_01]

    assign rd_hit = hit(reg_addr, `ORC_OFF_MODE)
                 || hit(reg_addr, `ORC_OFF_ADDR)
                 || hit(reg_addr, `ORC_OFF_DATA)
                 || hit(reg_addr, `ORC_OFF_SENT_CNT)
                 || hit(reg_addr, `ORC_OFF_RCVD_CNT);

    // register writes
    always @* begin
        rsv_bits_d = rsv_bits_q;
        opc_bits_d = opc_bits_q;
        opm_bits_d = opm_bits_q;
        cmd_addr_d = cmd_addr_q;
        cmd_data_d = cmd_data_q;
        if (wr_mode) begin
            // reserved bits stored as written; zero is software's duty
            rsv_bits_d = reg_wdata[`ORC_RSV_HI:`ORC_RSV_LO];  // [RULE_02]
            opc_bits_d = reg_wdata[`ORC_OPC_HI:`ORC_OPC_LO];  // [RULE_04]
            opm_bits_d = reg_wdata[`ORC_OPM_HI:`ORC_OPM_LO];
        end
        if (wr_addr) begin
            cmd_addr_d = reg_wdata;                           // [RULE_09]
        end
        if (wr_data) begin
            cmd_data_d = reg_wdata;                           // [RULE_10]
        end
    end

    // a command stays pending until its frame goes out; new issue wins
    always @* begin
        pending_d = remote_cmd_pending_q;
        if (tx_frame_valid) begin
            pending_d = 1'b0;
        end
        if (remote_cmd_issue && center_side) begin
            pending_d = 1'b1;                                 // [RULE_07] [RULE_08]
        end
    end

    // decoded mode for the frame builder
    always @* begin
        ext_d = is_ext(opm_bits_q);
        rsv_d = is_rsv_mode(opm_bits_q);                      // [RULE_06]
        opc_d = `ORC_OPC_READ_REPLY;
        if (ext_d) begin
            opc_d = opc_bits_q;                               // [RULE_04]
        end
    end

    // read path; unmapped addresses give no valid and zero data
    always @* begin
        rdata_d  = 8'h00;
        rvalid_d = 1'b0;
        if (reg_rd && rd_hit) begin
            rvalid_d = 1'b1;
            case (reg_addr)
                `ORC_OFF_MODE: begin
                    rdata_d = mode_word;                      // [RULE_03]
                end
                `ORC_OFF_ADDR: begin
                    rdata_d = cmd_addr_q;
                end
                `ORC_OFF_DATA: begin
                    rdata_d = cmd_data_q;
                end
                `ORC_OFF_SENT_CNT: begin
                    rdata_d = sent_count;                     // [RULE_11]
                end
                `ORC_OFF_RCVD_CNT: begin
                    rdata_d = received_count;                 // [RULE_12]
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // mode fields, reset from the tabulated image so extended mode is on
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rsv_bits_q <= mode_rst[`ORC_RSV_HI:`ORC_RSV_LO];  // [RULE_02]
            opc_bits_q <= mode_rst[`ORC_OPC_HI:`ORC_OPC_LO];
            opm_bits_q <= mode_rst[`ORC_OPM_HI:`ORC_OPM_LO];
        end else begin
            rsv_bits_q <= rsv_bits_d;
            opc_bits_q <= opc_bits_d;
            opm_bits_q <= opm_bits_d;
        end
    end

    // command bytes
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cmd_addr_q <= `ORC_ADDR_RST;
            cmd_data_q <= `ORC_DATA_RST;
        end else begin
            cmd_addr_q <= cmd_addr_d;
            cmd_data_q <= cmd_data_d;
        end
    end

    // pending flag; set beats clear in the same cycle
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            remote_cmd_pending_q <= 1'b0;
        end else begin
            remote_cmd_pending_q <= pending_d;
        end
    end

    // read answer, one cycle after the strobe
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rdata_q  <= rdata_d;
            reg_rvalid_q <= rvalid_d;
        end
    end

    // decoded levels registered so the frame builder sees no decode glitches
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_mode_q       <= 1'b0;
            operation_code_q <= 2'h0;
            mode_reserved_q  <= 1'b0;
        end else begin
            ext_mode_q       <= ext_d;
            operation_code_q <= opc_d;
            mode_reserved_q  <= rsv_d;
        end
    end

    // frame field selection, registered inside the mux
    orc_field_mux u_field_mux (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .ext_sel            (center_ext),
        .cmd_sel            (center_cmd),
        .own_model_0        (own_model_0),
        .own_model_1        (own_model_1),
        .own_model_2        (own_model_2),
        .cmd_mode           (mode_word),
        .cmd_addr           (cmd_addr_q),
        .cmd_data           (cmd_data_q),
        .model_info_field_q (model_info_field)
    );

    // both sides count sent frames
    orc_frame_counter #(
        .WIDTH (8)
    ) u_sent_cnt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inc     (tx_frame_valid),                            // [RULE_11]
        .clr     (cnt_clear),
        .count_q (sent_count)
    );

    // both sides count good received frames
    orc_frame_counter #(
        .WIDTH (8)
    ) u_rcvd_cnt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inc     (rx_good),                                   // [RULE_12]
        .clr     (cnt_clear),
        .count_q (received_count)
    );

endmodule // orc_regs
`default_nettype wire

// *** orc_defines.vh ***
// Purpose: offsets, field positions, reset values for the remote command bank
// Assumes: 8-bit management register space
// Notes: definitions only
`ifndef ORC_DEFINES_VH
`define ORC_DEFINES_VH

// register offsets
`define ORC_OFF_MODE        8'h4a
`define ORC_OFF_ADDR        8'h4b
`define ORC_OFF_DATA        8'h4c
`define ORC_OFF_SENT_CNT    8'h4d
`define ORC_OFF_RCVD_CNT    8'h4e
`define ORC_OFF_LOOPBACK    8'h44

// value written to the loop-back control register that clears the counters
`define ORC_CNT_CLEAR_VAL   8'h00

// mode register fields
`define ORC_RSV_HI          7
`define ORC_RSV_LO          6
`define ORC_CAP_HI          5
`define ORC_CAP_LO          4
`define ORC_OPC_HI          3
`define ORC_OPC_LO          2
`define ORC_OPM_HI          1
`define ORC_OPM_LO          0

// reset values
`define ORC_MODE_RST        8'h22
`define ORC_ADDR_RST        8'h00
`define ORC_DATA_RST        8'h00
`define ORC_CNT_RST         8'h00

// capability bits, read only
`define ORC_CAP_EXTENDED    2'h2

// operating mode codes
`define ORC_OPM_NORMAL      2'h0
`define ORC_OPM_EXTENDED    2'h2

// operation codes
`define ORC_OPC_READ_REPLY  2'h0
`define ORC_OPC_READ_REQ    2'h1
`define ORC_OPC_WRITE_REPLY 2'h2
`define ORC_OPC_WRITE_REQ   2'h3

`endif

// *** orc_frame_counter.v ***
// Purpose: 8-bit wrapping counter of valid maintenance frames
// Assumes: inc and clr are one-cycle pulses on ref_clk
// Notes: clear beats increment in the same cycle
`default_nettype none
`include "orc_defines.vh"

module orc_frame_counter #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // control
    input  wire             inc,
    input  wire             clr,
    // count
    output reg [WIDTH-1:0]  count_q
);

    reg [WIDTH-1:0] count_d;

    always @* begin
        count_d = count_q;
        if (clr) begin
            count_d = {WIDTH{1'b0}};                 // [RULE_13] [RULE_15]
        end else if (inc) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1}; // [RULE_15]
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

endmodule // orc_frame_counter
`default_nettype wire

// *** orc_field_mux.v ***
// Purpose: selects the 24-bit model-info field of the outgoing maintenance frame
// Assumes: select inputs are levels on ref_clk
// Notes: output registered, one cycle behind its inputs
`default_nettype none
`include "orc_defines.vh"

module orc_field_mux (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // selects
    input  wire        ext_sel,
    input  wire        cmd_sel,
    // own model bytes
    input  wire [7:0]  own_model_0,
    input  wire [7:0]  own_model_1,
    input  wire [7:0]  own_model_2,
    // remote command bytes
    input  wire [7:0]  cmd_mode,
    input  wire [7:0]  cmd_addr,
    input  wire [7:0]  cmd_data,
    // frame bits 47:24
    output reg  [23:0] model_info_field_q
);

    reg [23:0] model_info_field_d;

    always @* begin
        // normal mode: own model info bytes
        model_info_field_d = {own_model_2, own_model_1, own_model_0}; // [RULE_05]
        if (ext_sel) begin
            model_info_field_d = {cmd_data, cmd_addr, cmd_mode};       // [RULE_06]
        end else if (cmd_sel) begin
            model_info_field_d[15:8]  = cmd_addr;                      // [RULE_07]
            model_info_field_d[23:16] = cmd_data;                      // [RULE_08]
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            model_info_field_q <= 24'h00_0000;
        end else begin
            model_info_field_q <= model_info_field_d;
        end
    end

endmodule // orc_field_mux
`default_nettype wire

// *** orc_regs_chk.sv ***
// Purpose: concurrent checks on the remote command bank ports
// Assumes: one clock ref_clk, rst_n synchronous active low
// Notes: bound to orc_regs after the module
`default_nettype none
module orc_regs_chk (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_q,
    input wire logic        reg_rvalid_q,
    // role, command and frame events
    input wire logic        center_side,
    input wire logic        remote_cmd_issue,
    input wire logic [7:0]  own_model_0,
    input wire logic [7:0]  own_model_1,
    input wire logic [7:0]  own_model_2,
    input wire logic        tx_frame_valid,
    input wire logic        rx_frame_done,
    input wire logic        rx_crc_good,
    input wire logic        rx_opcode_valid,
    input wire logic        rx_dir_valid,
    // outputs
    input wire logic [23:0] model_info_field,
    input wire logic        ext_mode_q,
    input wire logic [1:0]  operation_code_q,
    input wire logic        remote_cmd_pending_q,
    input wire logic [7:0]  sent_count,
    input wire logic [7:0]  received_count
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic clr;
    logic rx_ok;
    logic mapped;
    assign clr    = reg_wr && reg_addr == 8'h44 && reg_wdata == 8'h00;
    assign rx_ok  = rx_frame_done && rx_crc_good && rx_opcode_valid && rx_dir_valid;
    assign mapped = reg_addr >= 8'h4a && reg_addr <= 8'h4e;

    sequence wr_ext;
        reg_wr && reg_addr == 8'h4a && reg_wdata[1:0] == 2'h2;
    endsequence
    sequence quiet2;
        !reg_wr ##1 !reg_wr;
    endsequence

    cap_bits_a: assert property (reg_rd && reg_addr == 8'h4a |=> reg_rvalid_q && reg_rdata_q[5:4] == 2'h2)
        else $error("capability bits wrong");
    unmapped_read_a: assert property (reg_rd && !mapped |=> !reg_rvalid_q && reg_rdata_q == 8'h00)
        else $error("unmapped read answered");
    ext_decode_a: assert property (wr_ext ##1 quiet2 |-> ext_mode_q && operation_code_q == $past(reg_wdata[3:2], 2))
        else $error("extended mode decode wrong");
    own_field_a: assert property (!center_side |=> model_info_field == $past({own_model_2, own_model_1, own_model_0}))
        else $error("terminal field not own bytes");
    pending_set_a: assert property (center_side && remote_cmd_issue |=> remote_cmd_pending_q)
        else $error("remote command not pending");
    sent_track_a: assert property (!clr |=> sent_count == $past(sent_count) + {7'h0, $past(tx_frame_valid)})
        else $error("sent count step wrong");
    recv_track_a: assert property (!clr |=> received_count == $past(received_count) + {7'h0, $past(rx_ok)})
        else $error("received count step wrong");
    count_clear_a: assert property (clr |=> sent_count == 8'h00 && received_count == 8'h00)
        else $error("counters not cleared");
endmodule // orc_regs_chk

bind orc_regs orc_regs_chk i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .center_side(center_side),
    .remote_cmd_issue(remote_cmd_issue), .own_model_0(own_model_0), .own_model_1(own_model_1),
    .own_model_2(own_model_2), .tx_frame_valid(tx_frame_valid), .rx_frame_done(rx_frame_done),
    .rx_crc_good(rx_crc_good), .rx_opcode_valid(rx_opcode_valid), .rx_dir_valid(rx_dir_valid),
    .model_info_field(model_info_field), .ext_mode_q(ext_mode_q), .operation_code_q(operation_code_q),
    .remote_cmd_pending_q(remote_cmd_pending_q), .sent_count(sent_count), .received_count(received_count)
);
`default_nettype wire

// *** orc_remote_peer.sv ***
// Purpose: remote converter sending maintenance frames across the link
// Assumes: frame flags change just after a rising edge of ref_clk
// Notes: qualifiers are garbage between frames, never left at the last value
`default_nettype none
module orc_remote_peer (
    // clock
    input  wire logic ref_clk,
    // received frame flags
    output var logic  rx_frame_done,
    output var logic  rx_crc_good,
    output var logic  rx_opcode_valid,
    output var logic  rx_dir_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_frame_done = 1'b0;
        {rx_crc_good, rx_opcode_valid, rx_dir_valid} = 3'h0;
    end

    // q is crc, opcode, direction; a low bit makes a frame the bank must not count
    task automatic send(input logic [2:0] q);
        @(posedge ref_clk);
        rx_frame_done <= 1'b1;
        {rx_crc_good, rx_opcode_valid, rx_dir_valid} <= q;
        @(posedge ref_clk);
        rx_frame_done <= 1'b0;
        {rx_crc_good, rx_opcode_valid, rx_dir_valid} <= ~q;
    endtask
endmodule // orc_remote_peer
`default_nettype wire

// *** oam_remote_command_regs_test.sv ***
// Purpose: self-checking bench for the remote command bank
// Assumes: inputs change by non-blocking assignment at rising edges
// Notes: a watchdog cuts a hang short
`default_nettype none
module oam_remote_command_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        center_side = 1'b0;
    logic        remote_cmd_issue = 1'b0;
    logic        tx_frame_valid = 1'b0;
    logic [7:0]  own_model_0 = 8'h00;
    logic [7:0]  own_model_1 = 8'h00;
    logic [7:0]  own_model_2 = 8'h00;
    logic        rx_frame_done, rx_crc_good, rx_opcode_valid, rx_dir_valid;
    logic [7:0]  reg_rdata_q, sent_count, received_count;
    logic        reg_rvalid_q, ext_mode_q, mode_reserved_q, remote_cmd_pending_q;
    logic [1:0]  operation_code_q;
    logic [23:0] model_info_field;
    int          errors = 0;
    int          checked = 0;

    always #5 ref_clk = ~ref_clk;

    orc_regs i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .center_side(center_side),
        .remote_cmd_issue(remote_cmd_issue), .own_model_0(own_model_0), .own_model_1(own_model_1),
        .own_model_2(own_model_2), .tx_frame_valid(tx_frame_valid), .rx_frame_done(rx_frame_done),
        .rx_crc_good(rx_crc_good), .rx_opcode_valid(rx_opcode_valid), .rx_dir_valid(rx_dir_valid),
        .model_info_field(model_info_field), .ext_mode_q(ext_mode_q), .operation_code_q(operation_code_q),
        .mode_reserved_q(mode_reserved_q), .remote_cmd_pending_q(remote_cmd_pending_q),
        .sent_count(sent_count), .received_count(received_count)
    );
    orc_remote_peer i_peer (
        .ref_clk(ref_clk), .rx_frame_done(rx_frame_done), .rx_crc_good(rx_crc_good),
        .rx_opcode_valid(rx_opcode_valid), .rx_dir_valid(rx_dir_valid)
    );

    task automatic report_and_stop();
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic vld);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read valid", {23'h0, vld}, {23'h0, reg_rvalid_q});
        chk("read data", {16'h0, exp}, {16'h0, reg_rdata_q});
    endtask

    task automatic tx_frames(input int n);
        @(posedge ref_clk);
        tx_frame_valid <= 1'b1;
        repeat (n) @(posedge ref_clk);
        tx_frame_valid <= 1'b0;
    endtask

    task automatic t_reset_values();
        rd(8'h4a, 8'h22, 1'b1);
        rd(8'h4b, 8'h00, 1'b1);
        rd(8'h4c, 8'h00, 1'b1);
        rd(8'h4d, 8'h00, 1'b1);
        rd(8'h4e, 8'h00, 1'b1);
        rd(8'h4f, 8'h00, 1'b0);
        rd(8'h44, 8'h00, 1'b0);
    endtask

    task automatic t_mode();
        for (int op = 0; op < 4; op++) begin
            wr(8'h4a, {2'h0, 2'h3, op[1:0], 2'h2});
            rd(8'h4a, {2'h0, 2'h2, op[1:0], 2'h2}, 1'b1);
            chk("ext mode", 24'h1, {23'h0, ext_mode_q});
            chk("op code", {22'h0, op[1:0]}, {22'h0, operation_code_q});
        end
        for (int m = 0; m < 4; m++) begin
            if (m != 2) begin
                wr(8'h4a, {4'h0, 2'h3, m[1:0]});
                tick(2);
                chk("ext mode", 24'h0, {23'h0, ext_mode_q});
                chk("reserved", {23'h0, m != 0}, {23'h0, mode_reserved_q});
                chk("op code", 24'h0, {22'h0, operation_code_q});
            end
        end
    endtask

    task automatic t_field();
        @(posedge ref_clk);
        center_side <= 1'b1;
        own_model_0 <= 8'h11;
        own_model_1 <= 8'h33;
        own_model_2 <= 8'h44;
        wr(8'h4b, 8'h5a);
        wr(8'h4c, 8'ha5);
        wr(8'h4a, 8'h00);
        tick(3);
        chk("normal field", 24'h4433_11, model_info_field);
        @(posedge ref_clk);
        remote_cmd_issue <= 1'b1;
        @(posedge ref_clk);
        remote_cmd_issue <= 1'b0;
        tick(3);
        chk("pending", 24'h1, {23'h0, remote_cmd_pending_q});
        chk("command field", 24'ha55a_11, model_info_field);
        tx_frames(1);
        tick(3);
        chk("pending", 24'h0, {23'h0, remote_cmd_pending_q});
        chk("normal field", 24'h4433_11, model_info_field);
        wr(8'h4a, 8'h0e);
        tick(3);
        chk("extended field", 24'ha55a_2e, model_info_field);
        @(posedge ref_clk);
        center_side <= 1'b0;
        tick(3);
        chk("terminal field", 24'h4433_11, model_info_field);
        @(posedge ref_clk);
        remote_cmd_issue <= 1'b1;
        @(posedge ref_clk);
        remote_cmd_issue <= 1'b0;
        tick(2);
        chk("terminal pending", 24'h0, {23'h0, remote_cmd_pending_q});
    endtask

    task automatic t_counters();
        wr(8'h44, 8'h00);
        tick(1);
        chk("sent count", 24'h0, {16'h0, sent_count});
        tx_frames(3);
        tick(1);
        chk("sent count", 24'h3, {16'h0, sent_count});
        i_peer.send(3'h7);
        i_peer.send(3'h7);
        i_peer.send(3'h3);
        i_peer.send(3'h5);
        i_peer.send(3'h6);
        rd(8'h4e, 8'h02, 1'b1);
        wr(8'h4d, 8'hff);
        rd(8'h4d, 8'h03, 1'b1);
        wr(8'h44, 8'h01);
        rd(8'h4d, 8'h03, 1'b1);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h44;
        reg_wdata <= 8'h00;
        tx_frame_valid <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        tx_frame_valid <= 1'b0;
        tick(1);
        chk("sent count", 24'h0, {16'h0, sent_count});
        chk("received count", 24'h0, {16'h0, received_count});
        tx_frames(255);
        tick(1);
        chk("sent count", 24'hff, {16'h0, sent_count});
        tx_frames(1);
        tick(1);
        chk("sent count", 24'h0, {16'h0, sent_count});
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_mode();
        t_field();
        t_counters();
        report_and_stop();
    end

    // whole run is near 380 cycles; this leaves wide margin
    initial begin
        #50us;
        errors++;
        report_and_stop();
    end
endmodule // oam_remote_command_regs_test
`default_nettype wire
